// ---- src/isar_pkg.sv ----
package isar_pkg;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [31:0] ADDR_BUS_STATUS    = 32'h5000_1370;
  localparam logic [31:0] ADDR_TX_LEVEL      = 32'h5000_1374;
  localparam logic [31:0] ADDR_RX_LEVEL      = 32'h5000_1378;
  localparam logic [31:0] ADDR_HOLD_TIME     = 32'h5000_137C;
  localparam logic [31:0] ADDR_ABORT_CAUSE   = 32'h5000_1380;
  localparam logic [31:0] ADDR_IRQ_STATUS    = 32'h5000_1384;
  localparam logic [31:0] ADDR_IRQ_MASK      = 32'h5000_1388;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned ST_SLAVE_BUSY      = 6;
  localparam int unsigned ST_MASTER_BUSY     = 5;
  localparam int unsigned ST_RX_FULL         = 4;
  localparam int unsigned ST_RX_NOT_EMPTY    = 3;
  localparam int unsigned ST_TX_EMPTY        = 2;
  localparam int unsigned ST_TX_NOT_FULL     = 1;
  localparam int unsigned ST_ACTIVITY        = 0;
  localparam int unsigned AB_SLAVE_READ_BAD  = 15;
  localparam int unsigned AB_SLAVE_LOST      = 14;
  localparam int unsigned AB_STALE_FLUSH     = 13;
  localparam int unsigned AB_ARB_LOSS        = 12;
  localparam int unsigned AB_MASTER_DIS      = 11;
  localparam int unsigned AB_TEN_BIT_READ    = 10;
  localparam int unsigned IRQ_ABORT          = 0;
  localparam int unsigned IRQ_RX_FULL        = 1;

  // ----------------------------------------
  // sizes, resets, bus answers
  // ----------------------------------------
  localparam int unsigned CNT_W              = 6;
  localparam logic [5:0]  FIFO_DEPTH         = 6'h20;
  localparam logic [15:0] HOLD_RESET         = 16'h0001;
  localparam logic [1:0]  PIN_RESET          = 2'h3;
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef struct packed {
    logic        aw_held;
    logic [31:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] hold;
    logic [15:0] cause;
    logic [1:0]  istat;
    logic [1:0]  imask;
    logic        rx_full_d;
    logic        abort_evt;
    logic        irq;
  } isar_state_type;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
    logic [1:0] rise;
  } isar_sync_type;

endpackage

// ---- src/isar_pin_sync.sv ----
`timescale 1ns/1ps
module isar_pin_sync
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bus pins, index 0 clock line, 1 data line
  input  wire logic [1:0] pin_in,
  // filtered levels and rising edges
  output logic      [1:0] pin_level,
  output logic      [1:0] pin_rise
);

  isar_pkg::isar_sync_type st_r;
  isar_pkg::isar_sync_type st_nxt;

  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // change counts only once two late stages agree
    for (int i = 0; i < 2; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
        st_nxt.lvl[i] = st_r.s2[i];
      st_nxt.rise[i] = st_nxt.lvl[i] & ~st_r.lvl[i];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r      <= '0;
      st_r.s1   <= isar_pkg::PIN_RESET;
      st_r.s2   <= isar_pkg::PIN_RESET;
      st_r.s3   <= isar_pkg::PIN_RESET;
      st_r.lvl  <= isar_pkg::PIN_RESET;
    end
    else
      st_r <= st_nxt;
  end

  assign pin_level = st_r.lvl;
  assign pin_rise  = st_r.rise;

endmodule // isar_pin_sync

// ---- src/isar_bus_check.sv ----
`timescale 1ns/1ps
module isar_bus_check
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // filtered bus view
  input  wire logic scl_rise,
  input  wire logic sda_level,
  // transmitter side
  input  wire logic tx_active,
  input  wire logic sda_tx_bit,
  // loss of ownership, one-cycle pulse
  output logic      bus_lost
);

  logic lost_r;
  logic lost_nxt;

  always_comb
  begin
    // line not what we drove at clock rise: someone else owns it
    lost_nxt = tx_active && scl_rise && (sda_level != sda_tx_bit);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lost_r <= 1'b0;
    else
      lost_r <= lost_nxt;
  end

  assign bus_lost = lost_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_mismatch_loss: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_active && scl_rise && sda_level != sda_tx_bit) |=> bus_lost)
    else $error("data mismatch at clock rise not flagged");
  a_loss_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    bus_lost |-> $past(scl_rise) && $past(tx_active))
    else $error("loss flagged without a clock rise while sending");

endmodule // isar_bus_check

// ---- src/isar_top.sv ----
`timescale 1ns/1ps
module isar_top
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // register bus, write side
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // register bus, read side
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // state machine activity
  input  wire logic        slave_fsm_busy,
  input  wire logic        master_fsm_busy,
  // queue fill counts
  input  wire logic [5:0]  tx_queue_count,
  input  wire logic [5:0]  rx_queue_count,
  // slave side events
  input  wire logic        slave_read_active,
  input  wire logic        slave_read_req,
  input  wire logic        data_command_port_wr,
  input  wire logic        data_command_read_bit,
  input  wire logic        slave_tx_active,
  // master side events
  input  wire logic        master_tx_active,
  input  wire logic        master_start_req,
  input  wire logic        master_mode_enable,
  input  wire logic        master_read_req,
  input  wire logic        ten_bit_addr,
  input  wire logic        repeat_start_enable,
  // bus pins and bit being sent
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        sda_tx_bit,
  // results
  output logic             transmit_abort_event,
  output logic      [15:0] data_line_hold_cycles,
  output logic             irq
);

  // ----------------------------------------
  // pin filter and ownership check
  // ----------------------------------------
  logic [1:0] pin_level;
  logic [1:0] pin_rise;
  logic       bus_lost;

  isar_pin_sync u_sync
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    ({sda_in, scl_in}),
    .pin_level (pin_level),
    .pin_rise  (pin_rise)
  );

  isar_bus_check u_check
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .scl_rise   (pin_rise[0]),
    .sda_level  (pin_level[1]),
    .tx_active  (master_tx_active | slave_tx_active),
    .sda_tx_bit (sda_tx_bit),
    .bus_lost   (bus_lost)
  );

  // ----------------------------------------
  // live status words
  // ----------------------------------------
  logic [15:0] status_word;
  logic        rx_full;

  always_comb
  begin
    rx_full     = (rx_queue_count == isar_pkg::FIFO_DEPTH);
    status_word = '0;
    status_word[isar_pkg::ST_SLAVE_BUSY]   = slave_fsm_busy;
    status_word[isar_pkg::ST_MASTER_BUSY]  = master_fsm_busy;
    status_word[isar_pkg::ST_RX_FULL]      = rx_full;
    status_word[isar_pkg::ST_RX_NOT_EMPTY] = (rx_queue_count != 6'h00);
    // empty queue is a level only, kept out of the interrupt vector
    status_word[isar_pkg::ST_TX_EMPTY]     = (tx_queue_count == 6'h00);
    status_word[isar_pkg::ST_TX_NOT_FULL]  = (tx_queue_count != isar_pkg::FIFO_DEPTH);
    // roles tracked apart, either one marks the bus busy
    status_word[isar_pkg::ST_ACTIVITY]     = slave_fsm_busy | master_fsm_busy;
  end

  // ----------------------------------------
  // abort causes
  // ----------------------------------------
  logic [15:0] cause_set;

  always_comb
  begin
    cause_set = '0;
    cause_set[isar_pkg::AB_SLAVE_READ_BAD] =
      data_command_port_wr && data_command_read_bit && slave_read_active;
    cause_set[isar_pkg::AB_SLAVE_LOST] = bus_lost && slave_tx_active;
    cause_set[isar_pkg::AB_STALE_FLUSH] =
      slave_read_req && (tx_queue_count != 6'h00);
    // shared loss bit, bit 14 tells the slave case apart
    cause_set[isar_pkg::AB_ARB_LOSS] = bus_lost;
    cause_set[isar_pkg::AB_MASTER_DIS] =
      master_start_req && !master_mode_enable;
    cause_set[isar_pkg::AB_TEN_BIT_READ] =
      master_read_req && ten_bit_addr && !repeat_start_enable;
  end

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  function automatic logic [33:0] read_mux(input logic [31:0] addr,
                                           input logic [15:0] hold,
                                           input logic [15:0] cause,
                                           input logic [1:0]  istat,
                                           input logic [1:0]  imask);
    logic [33:0] res;
    res = {isar_pkg::RESP_OKAY, 32'h0000_0000};
    unique case (addr)
      isar_pkg::ADDR_BUS_STATUS:  res[15:0] = status_word;
      isar_pkg::ADDR_TX_LEVEL:    res[5:0]  = tx_queue_count;
      isar_pkg::ADDR_RX_LEVEL:    res[5:0]  = rx_queue_count;
      isar_pkg::ADDR_HOLD_TIME:   res[15:0] = hold;
      isar_pkg::ADDR_ABORT_CAUSE: res[15:0] = cause;
      isar_pkg::ADDR_IRQ_STATUS:  res[1:0]  = istat;
      isar_pkg::ADDR_IRQ_MASK:    res[1:0]  = imask;
      default:                    res[33:32] = isar_pkg::RESP_SLVERR;
    endcase
    return res;
  endfunction

  // ----------------------------------------
  // state update
  // ----------------------------------------
  isar_pkg::isar_state_type st_r;
  isar_pkg::isar_state_type st_nxt;
  logic [1:0]               irq_clr;
  logic [1:0]               irq_set;

  assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_held && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;

  always_comb
  begin
    st_nxt  = st_r;
    irq_clr = '0;
    irq_set = '0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;
    // write takes effect once both halves are in
    if (st_nxt.aw_held && st_nxt.w_held)
    begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = isar_pkg::RESP_OKAY;
      unique case (st_nxt.aw_addr)
        isar_pkg::ADDR_HOLD_TIME:
        begin
          if (st_nxt.w_strb[0])
            st_nxt.hold[7:0] = st_nxt.w_data[7:0];
          if (st_nxt.w_strb[1])
            st_nxt.hold[15:8] = st_nxt.w_data[15:8];
        end
        isar_pkg::ADDR_IRQ_STATUS:
          if (st_nxt.w_strb[0])
            irq_clr = st_nxt.w_data[1:0];
        isar_pkg::ADDR_IRQ_MASK:
          if (st_nxt.w_strb[0])
            st_nxt.imask = st_nxt.w_data[1:0];
        isar_pkg::ADDR_BUS_STATUS, isar_pkg::ADDR_TX_LEVEL,
        isar_pkg::ADDR_RX_LEVEL, isar_pkg::ADDR_ABORT_CAUSE: ;
        default:
          st_nxt.bresp = isar_pkg::RESP_SLVERR;
      endcase
    end
    if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_nxt.rvalid = 1'b1;
      {st_nxt.rresp, st_nxt.rdata} =
        read_mux(s_axi_araddr, st_r.hold, st_r.cause, st_r.istat, st_r.imask);
    end
    // causes stay until the abort flag is cleared; new events win
    if (irq_clr[isar_pkg::IRQ_ABORT])
      st_nxt.cause = '0;
    st_nxt.cause     = st_nxt.cause | cause_set;
    st_nxt.abort_evt = |cause_set;
    st_nxt.rx_full_d = rx_full;
    irq_set[isar_pkg::IRQ_ABORT]   = |cause_set;
    irq_set[isar_pkg::IRQ_RX_FULL] = rx_full && !st_r.rx_full_d;
    st_nxt.istat = (st_r.istat & ~irq_clr) | irq_set;
    st_nxt.irq   = |(st_nxt.istat & st_nxt.imask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r      <= '0;
      st_r.hold <= isar_pkg::HOLD_RESET;
    end
    else
      st_r <= st_nxt;
  end

  assign s_axi_bvalid          = st_r.bvalid;
  assign s_axi_bresp           = st_r.bresp;
  assign s_axi_rvalid          = st_r.rvalid;
  assign s_axi_rdata           = st_r.rdata;
  assign s_axi_rresp           = st_r.rresp;
  assign transmit_abort_event  = st_r.abort_evt;
  assign data_line_hold_cycles = st_r.hold;
  assign irq                   = st_r.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic ar_hs;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  a_slave_busy_read: assert property (
    (ar_hs && s_axi_araddr == isar_pkg::ADDR_BUS_STATUS)
      |=> s_axi_rvalid && s_axi_rdata[6] == $past(slave_fsm_busy))
    else $error("slave busy bit wrong");
  a_master_busy_read: assert property (
    (ar_hs && s_axi_araddr == isar_pkg::ADDR_BUS_STATUS)
      |=> s_axi_rdata[5] == $past(master_fsm_busy))
    else $error("master busy bit wrong");
  a_rx_full_read: assert property (
    (ar_hs && s_axi_araddr == isar_pkg::ADDR_BUS_STATUS)
      |=> s_axi_rdata[4] == ($past(rx_queue_count) == isar_pkg::FIFO_DEPTH))
    else $error("receive full bit wrong");
  a_rx_nonempty_read: assert property (
    (ar_hs && s_axi_araddr == isar_pkg::ADDR_BUS_STATUS)
      |=> s_axi_rdata[3] == ($past(rx_queue_count) != 6'h00))
    else $error("receive not empty bit wrong");
  a_tx_empty_read: assert property (
    (ar_hs && s_axi_araddr == isar_pkg::ADDR_BUS_STATUS)
      |=> s_axi_rdata[2] == ($past(tx_queue_count) == 6'h00) && s_axi_rdata[31:7] == '0)
    else $error("transmit empty bit wrong");
  a_tx_nofull_read: assert property (
    (ar_hs && s_axi_araddr == isar_pkg::ADDR_BUS_STATUS)
      |=> s_axi_rdata[1] == ($past(tx_queue_count) != isar_pkg::FIFO_DEPTH))
    else $error("transmit not full bit wrong");
  a_activity_read: assert property (
    (ar_hs && s_axi_araddr == isar_pkg::ADDR_BUS_STATUS)
      |=> s_axi_rdata[0] == $past(slave_fsm_busy || master_fsm_busy))
    else $error("activity bit wrong");
  a_tx_level_read: assert property (
    (ar_hs && s_axi_araddr == isar_pkg::ADDR_TX_LEVEL)
      |=> s_axi_rdata == {26'h0, $past(tx_queue_count)})
    else $error("transmit level wrong");
  a_rx_level_read: assert property (
    (ar_hs && s_axi_araddr == isar_pkg::ADDR_RX_LEVEL)
      |=> s_axi_rdata == {26'h0, $past(rx_queue_count)})
    else $error("receive level wrong");
  a_bad_read_cmd: assert property (
    (data_command_port_wr && data_command_read_bit && slave_read_active)
      |=> st_r.cause[15] && transmit_abort_event)
    else $error("bad read command not recorded");
  a_slave_loss: assert property (
    (bus_lost && slave_tx_active) |=> st_r.cause[14] && st_r.cause[12])
    else $error("slave loss bits not set together");
  a_stale_flush: assert property (
    (slave_read_req && tx_queue_count != 6'h00)
      |=> st_r.cause[13] && transmit_abort_event)
    else $error("stale data flush missing");
  a_master_loss: assert property (
    (bus_lost && master_tx_active && !slave_tx_active && !st_r.cause[14])
      |=> st_r.cause[12] && !st_r.cause[14])
    else $error("master arbitration loss missing");
  a_master_disabled: assert property (
    (master_start_req && !master_mode_enable)
      |=> st_r.cause[11] && st_r.istat[0] && (irq || !st_r.imask[0]))
    else $error("disabled master attempt missing");
  a_ten_bit_read: assert property (
    (master_read_req && ten_bit_addr && !repeat_start_enable) |=> st_r.cause[10])
    else $error("ten bit read abort missing");
  // only abort causes and a filling receive queue may raise the vector
  a_empty_no_irq: assert property (
    (st_r.istat == 2'h0 && cause_set == 16'h0000 && !rx_full)
      |=> st_r.istat == 2'h0)
    else $error("interrupt raised without cause");
  a_both_roles: assert property (
    (ar_hs && s_axi_araddr == isar_pkg::ADDR_BUS_STATUS && slave_fsm_busy && master_fsm_busy)
      |=> s_axi_rdata[6:5] == 2'h3 && s_axi_rdata[0])
    else $error("roles not tracked apart");

  c_both_roles:    cover property (slave_fsm_busy && master_fsm_busy);
  c_slave_loss:    cover property (bus_lost && slave_tx_active);
  c_flush_irq:     cover property (transmit_abort_event ##1 irq);
  c_hold_write:    cover property (s_axi_bvalid && st_r.hold != isar_pkg::HOLD_RESET);

endmodule // isar_top

// ---- verification/isar_bus_partner.sv ----
`timescale 1ns/1ps
module isar_bus_partner
(
  // bus lines, pulled up while released
  output logic scl,
  output logic sda
);
  // ----------------------------------------
  // remote master, one bit per frame
  // ----------------------------------------
  localparam time HALF = 400ns;

  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // start condition, then one data bit up to the clock rise
  task automatic send(input logic b);
    sda = 1'b0;
    #HALF;
    scl = 1'b0;
    sda = b;
    #HALF;
    scl = 1'b1;
  endtask

  // stop condition; clock then stands high, so no stray rise between frames
  task automatic finish();
    #HALF;
    scl = 1'b0;
    #HALF;
    sda = 1'b0;
    #HALF;
    scl = 1'b1;
    #HALF;
    sda = 1'b1;
  endtask
endmodule // isar_bus_partner

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [31:0] A_ST = isar_pkg::ADDR_BUS_STATUS;
  localparam logic [31:0] A_TX = isar_pkg::ADDR_TX_LEVEL;
  localparam logic [31:0] A_RX = isar_pkg::ADDR_RX_LEVEL;
  localparam logic [31:0] A_HD = isar_pkg::ADDR_HOLD_TIME;
  localparam logic [31:0] A_AB = isar_pkg::ADDR_ABORT_CAUSE;
  localparam logic [31:0] A_IS = isar_pkg::ADDR_IRQ_STATUS;
  localparam logic [31:0] A_IM = isar_pkg::ADDR_IRQ_MASK;
  localparam logic [1:0]  OK   = isar_pkg::RESP_OKAY;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        sbusy, mbusy, rd_act, rd_req, dc_wr, dc_rd, s_tx, m_tx, st_req, m_en, m_rd, ten, rs_en;
  logic [5:0]  txc, rxc;
  logic        scl, sda, tx_bit, evt, irq, im;
  logic [15:0] hold;
  int          n_mismatch, checks_done;

  isar_top dut
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .slave_fsm_busy(sbusy), .master_fsm_busy(mbusy), .tx_queue_count(txc), .rx_queue_count(rxc),
    .slave_read_active(rd_act), .slave_read_req(rd_req), .data_command_port_wr(dc_wr),
    .data_command_read_bit(dc_rd), .slave_tx_active(s_tx), .master_tx_active(m_tx),
    .master_start_req(st_req), .master_mode_enable(m_en), .master_read_req(m_rd), .ten_bit_addr(ten),
    .repeat_start_enable(rs_en), .scl_in(scl), .sda_in(sda), .sda_tx_bit(tx_bit),
    .transmit_abort_event(evt), .data_line_hold_cycles(hold), .irq(irq)
  );
  isar_bus_partner link
  (
    .scl(scl),
    .sda(sda)
  );

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic tmo(input string nm);
    $display("unexpected %s: expected answer, seen timeout", nm);
    n_mismatch++;
    stop_test();
  endtask

  task automatic idle_in();
    {sbusy, mbusy, rd_act, rd_req, dc_wr, dc_rd, s_tx, m_tx} <= 8'h00;
    {st_req, m_en, m_rd, ten, rs_en, tx_bit} <= 6'b010011;
    txc <= 6'h00;
    rxc <= 6'h00;
  endtask

  // write address and data offered together, each released once taken
  task automatic axw(input logic [31:0] a, d);
    int n;
    logic got;
    got = 1'b0;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    for (n = 0; n < 40 && !got; n++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      got = (bvalid === 1'b1);
    end
    bready <= 1'b0;
    if (!got)
      tmo("write answer");
    chk("write response", {30'h0, OK}, {30'h0, bresp});
  endtask

  task automatic axr(input string nm, input logic [31:0] a, exp, input logic [1:0] er);
    int n;
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (n = 0; n < 40 && !got; n++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      got = (rvalid === 1'b1);
    end
    rready <= 1'b0;
    if (!got)
      tmo(nm);
    chk(nm, exp, rdata);
    chk("read response", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic st(input logic s, m, input logic [5:0] rx, tx, input logic [31:0] exp);
    @(posedge aclk);
    {sbusy, mbusy, rxc, txc} <= {s, m, rx, tx};
    axr("status", A_ST, exp, OK);
    axr("tx level", A_TX, {26'h0, tx}, OK);
    axr("rx level", A_RX, {26'h0, rx}, OK);
  endtask

  task automatic fire(input int k, input logic [31:0] exp, input logic ei);
    @(posedge aclk);
    case (k)
      0: {st_req, m_en} <= 2'b10;
      1: {m_rd, ten, rs_en} <= 3'b110;
      2: {dc_wr, dc_rd, rd_act} <= 3'b111;
      3: {rd_req, txc} <= {1'b1, 6'h02};
      4: rd_req <= 1'b1;
      default: st_req <= 1'b1;
    endcase
    @(posedge aclk);
    idle_in();
    #1;
    chk("abort event", {31'h0, ei}, {31'h0, evt});
    @(posedge aclk);
    #1;
    chk("abort event end", 32'h0, {31'h0, evt});
    axr("cause", A_AB, exp, OK);
    chk("irq", {31'h0, ei & im}, {31'h0, irq});
    axw(A_IS, 32'h1);
    axr("cause cleared", A_AB, 32'h0, OK);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask

  task automatic lose(input logic sa, ma, b, input logic [31:0] exp);
    int n;
    logic seen;
    seen = 1'b0;
    @(posedge aclk);
    {s_tx, m_tx, tx_bit} <= {sa, ma, 1'b1};
    link.send(b);
    for (n = 0; n < 30 && !seen; n++)
    begin
      @(posedge aclk);
      seen = (evt === 1'b1);
    end
    {s_tx, m_tx} <= 2'b00;
    link.finish();
    chk("loss event", {31'h0, exp != 0}, {31'h0, seen});
    axr("loss cause", A_AB, exp, OK);
    axw(A_IS, 32'h1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    axr("reset status", A_ST, 32'h6, OK);
    axr("reset hold", A_HD, 32'h1, OK);
    axr("reset cause", A_AB, 32'h0, OK);
    axr("unmapped", A_IM + 32'h4, 32'h0, isar_pkg::RESP_SLVERR);
    chk("hold port", 32'h1, {16'h0, hold});
    st(1'b1, 1'b1, 6'h20, 6'h20, 32'h79);
    st(1'b0, 1'b1, 6'h01, 6'h1F, 32'h2B);
    st(1'b1, 1'b0, 6'h00, 6'h00, 32'h47);
    st(1'b0, 1'b0, 6'h00, 6'h00, 32'h06);
    axw(A_TX, 32'h3F);
    axr("tx level kept", A_TX, 32'h0, OK);
    axw(A_HD, 32'hFFFF_ABCD);
    axr("hold", A_HD, 32'hABCD, OK);
    chk("hold port", 32'hABCD, {16'h0, hold});
    $display("register test done");
  endtask

  // receive-full event is set, masked, unmasked and cleared; empty transmit queue adds nothing
  task automatic t_irq();
    axr("irq status", A_IS, 32'h2, OK);
    chk("irq masked", 32'h0, {31'h0, irq});
    axw(A_IM, 32'h2);
    #1;
    chk("irq unmasked", 32'h1, {31'h0, irq});
    axw(A_IS, 32'h3);
    axr("irq status cleared", A_IS, 32'h0, OK);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("interrupt test done");
  endtask

  task automatic t_abort();
    im = 1'b0;
    axw(A_IM, 32'h0);
    fire(0, 32'h0800, 1'b1);
    axw(A_IM, 32'h1);
    im = 1'b1;
    fire(0, 32'h0800, 1'b1);
    fire(1, 32'h0400, 1'b1);
    fire(2, 32'h8000, 1'b1);
    fire(3, 32'h2000, 1'b1);
    fire(4, 32'h0, 1'b0);
    fire(5, 32'h0, 1'b0);
    lose(1'b1, 1'b0, 1'b0, 32'h5000);
    lose(1'b0, 1'b1, 1'b0, 32'h1000);
    lose(1'b1, 1'b0, 1'b1, 32'h0);
    lose(1'b0, 1'b0, 1'b0, 32'h0);
    $display("abort test done");
  endtask

  initial
  begin
    n_mismatch = 0;
    checks_done = 0;
    im = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, wstrb, araddr} = 100'h0;
    idle_in();
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_irq();
    t_abort();
    stop_test();
  end
endmodule // testbench
